// ==== pkg/tx_thresh_pkg.sv ====
// Shared constants, field layouts and carrier types for the transmit descriptor threshold block
package tx_thresh_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 16;
  localparam logic [15:0] ADDR_PKT_DELAY = 16'h3820;
  localparam logic [15:0] ADDR_QUEUE_CTL = 16'h3828;
  localparam logic [15:0] ADDR_ABS_DELAY = 16'h382C;
  localparam logic [15:0] ADDR_STATUS    = 16'h3830;

  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [31:0] QUEUE_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] DELAY_RESET     = 32'h0000_0000;
  localparam logic [31:0] QUEUE_CTL_MASK  = 32'hFF3F_3F3F;
  localparam logic [31:0] DELAY_MASK      = 32'h0000_FFFF;
  localparam int unsigned FLUSH_BIT       = 31;
  localparam int unsigned FLUSH_LANE      = 3;

  // ----------------------------------------------------------------
  // Descriptor geometry
  // ----------------------------------------------------------------
  localparam int unsigned DESC_BYTES      = 16;
  localparam int unsigned DESC_SHIFT      = 4;
  localparam int unsigned LINE_DESC_SHIFT = 4;
  localparam int unsigned LOW_SHIFT       = 3;
  localparam int unsigned CNT_W           = 8;
  localparam int unsigned BYTES_W         = CNT_W + DESC_SHIFT;
  localparam logic [7:0]  BUF_DESC        = 8'h40;
  localparam int unsigned THR_W           = 6;
  localparam int unsigned DELAY_W         = 16;

  // ----------------------------------------------------------------
  // Timer tick: 1.024 us derived from the 25 ns core clock
  // ----------------------------------------------------------------
  localparam int unsigned TICK_NS       = 1024;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ACC_W         = 11;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_NS);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(TICK_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0]       low_level;
    logic             granularity;
    logic [1:0]       rsv2;
    logic [THR_W-1:0] writeback;
    logic [1:0]       rsv1;
    logic [THR_W-1:0] host_avail;
    logic [1:0]       rsv0;
    logic [THR_W-1:0] prefetch;
  } queue_ctl_t;

  typedef struct packed {
    logic done;
    logic tx_ok;
    logic report_status;
    logic irq_delay_enable;
  } desc_event_t;

  typedef enum logic {
    REQ_IDLE = 1'b0,
    REQ_BUSY = 1'b1
  } req_state_t;

endpackage

// ==== rtl/delay_timer.sv ====
// Reloadable countdown timer counting in prescaler ticks
`timescale 1ns/100ps
module delay_timer (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              tick_i,
  input  wire logic                              start_i,
  input  wire logic                              halt_i,
  input  wire logic [tx_thresh_pkg::DELAY_W-1:0] reload_i,
  output logic                                   running_o,
  output logic                                   expire_o
);

  logic [tx_thresh_pkg::DELAY_W-1:0] count;
  wire last = count <= tx_thresh_pkg::DELAY_W'(1);

  // Halt beats start so a cancel in the same cycle never leaves a live countdown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count     <= '0;
      running_o <= 1'b0;
      expire_o  <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (halt_i) begin
        count     <= reload_i;
        running_o <= 1'b0;
      end else if (start_i) begin
        count     <= reload_i;
        running_o <= reload_i != '0;
      end else if (running_o && tick_i) begin
        if (last) begin
          running_o <= 1'b0;
          expire_o  <= 1'b1;
        end else begin
          count <= count - tx_thresh_pkg::DELAY_W'(1);
        end
      end
    end
  end

endmodule

// ==== rtl/tick_prescaler.sv ====
// Free-running fractional prescaler producing the 1.024 us timer tick
`timescale 1ns/100ps
module tick_prescaler (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);

  logic [tx_thresh_pkg::ACC_W-1:0] acc;
  wire  [tx_thresh_pkg::ACC_W-1:0] acc_sum  = acc + tx_thresh_pkg::ACC_STEP;
  wire                             wrap     = acc_sum >= tx_thresh_pkg::ACC_WRAP;
  // Fractional carry keeps the long-run tick rate exact although 1024/25 is not whole
  wire  [tx_thresh_pkg::ACC_W-1:0] next_acc = wrap ? acc_sum - tx_thresh_pkg::ACC_WRAP : acc_sum;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc    <= '0;
      tick_o <= 1'b0;
    end else begin
      acc    <= next_acc;
      tick_o <= wrap;
    end
  end

endmodule

// ==== rtl/tx_descriptor_threshold_ctrl.sv ====
// Transmit descriptor prefetch, write-back and interrupt-delay control
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module tx_descriptor_threshold_ctrl (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  // Wishbone classic slave
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [tx_thresh_pkg::ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]                            wb_sel_i,
  input  wire logic [31:0]                           wb_dat_i,
  output logic      [31:0]                           wb_dat_o,
  output logic                                       wb_ack_o,
  // Descriptor processing and ring state
  input  wire tx_thresh_pkg::desc_event_t            desc_event_i,
  input  wire logic [15:0]                           host_avail_i,
  // Prefetch request to the descriptor mover
  output logic                                       fetch_req_o,
  output logic      [tx_thresh_pkg::CNT_W-1:0]       fetch_count_o,
  output logic      [tx_thresh_pkg::BYTES_W-1:0]     fetch_bytes_o,
  input  wire logic                                  fetch_ack_i,
  // Write-back request to the descriptor mover
  output logic                                       writeback_req_o,
  output logic      [tx_thresh_pkg::CNT_W-1:0]       writeback_count_o,
  output logic      [tx_thresh_pkg::BYTES_W-1:0]     writeback_bytes_o,
  input  wire logic                                  writeback_ack_i,
  // Interrupt causes towards the cause register
  output logic                                       tx_complete_cause_o,
  output logic                                       desc_low_cause_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  sel,
                                              input logic [31:0] mask);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Threshold in descriptors; a cache line holds 16 descriptors
  function automatic logic [15:0] thr_to_desc(input logic [tx_thresh_pkg::THR_W-1:0] thr,
                                              input logic                             per_desc);
    logic [15:0] wide;
    wide = 16'(thr);
    return per_desc ? wide : wide << tx_thresh_pkg::LINE_DESC_SHIFT;
  endfunction

  function automatic logic [tx_thresh_pkg::BYTES_W-1:0] to_bytes(
      input logic [tx_thresh_pkg::CNT_W-1:0] cnt);
    return tx_thresh_pkg::BYTES_W'(cnt) << tx_thresh_pkg::DESC_SHIFT;
  endfunction

  function automatic logic word_hit(input logic [tx_thresh_pkg::ADR_W-1:0] adr,
                                    input logic [15:0]                     reg_adr);
    return adr[tx_thresh_pkg::ADR_W-1:2] == reg_adr[15:2];
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  tx_thresh_pkg::queue_ctl_t qctl;
  logic [31:0]               abs_delay;
  logic [31:0]               pkt_delay;

  wire bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master samples ack, as it sees them
  wire bus_wr     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire hit_qctl   = word_hit(wb_adr_i, tx_thresh_pkg::ADDR_QUEUE_CTL);
  wire hit_abs    = word_hit(wb_adr_i, tx_thresh_pkg::ADDR_ABS_DELAY);
  wire hit_pkt    = word_hit(wb_adr_i, tx_thresh_pkg::ADDR_PKT_DELAY);
  wire hit_status = word_hit(wb_adr_i, tx_thresh_pkg::ADDR_STATUS);

  // Flush is write-only and self-clearing: it acts once and reads back as zero
  wire flush_pulse = bus_wr && hit_pkt && wb_sel_i[tx_thresh_pkg::FLUSH_LANE]
                     && wb_dat_i[tx_thresh_pkg::FLUSH_BIT];

  wire [31:0] next_qctl = merge_bytes(qctl, wb_dat_i, wb_sel_i,
                                      tx_thresh_pkg::QUEUE_CTL_MASK);
  wire [31:0] next_abs  = merge_bytes(abs_delay, wb_dat_i, wb_sel_i,
                                      tx_thresh_pkg::DELAY_MASK);
  wire [31:0] next_pkt  = merge_bytes(pkt_delay, wb_dat_i, wb_sel_i,
                                      tx_thresh_pkg::DELAY_MASK);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qctl      <= tx_thresh_pkg::QUEUE_CTL_RESET;
      abs_delay <= tx_thresh_pkg::DELAY_RESET;
      pkt_delay <= tx_thresh_pkg::DELAY_RESET;
    end else if (bus_wr) begin
      if (hit_qctl) begin
        qctl <= next_qctl;
      end
      if (hit_abs) begin
        abs_delay <= next_abs;
      end
      if (hit_pkt) begin
        pkt_delay <= next_pkt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Threshold decode
  // ----------------------------------------------------------------
  wire [15:0] prefetch_desc  = thr_to_desc(qctl.prefetch, qctl.granularity);
  wire [15:0] host_desc      = thr_to_desc(qctl.host_avail, qctl.granularity);
  wire [15:0] writeback_desc = thr_to_desc(qctl.writeback, qctl.granularity);
  wire        burst_mode     = qctl.writeback != '0;

  wire [tx_thresh_pkg::DELAY_W-1:0] abs_reload = abs_delay[tx_thresh_pkg::DELAY_W-1:0];
  wire [tx_thresh_pkg::DELAY_W-1:0] pkt_reload = pkt_delay[tx_thresh_pkg::DELAY_W-1:0];

  // ----------------------------------------------------------------
  // Descriptor events and interrupt-delay timers
  // ----------------------------------------------------------------
  wire desc_done = desc_event_i.done;
  wire delayed   = desc_done && desc_event_i.tx_ok && desc_event_i.report_status
                   && desc_event_i.irq_delay_enable;
  wire immediate = desc_done && desc_event_i.report_status
                   && !desc_event_i.irq_delay_enable;

  logic tick;
  logic abs_running;
  logic abs_expire;
  logic pkt_running;
  logic pkt_expire;

  tick_prescaler u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // Absolute timer is not re-armed by later descriptors, which bounds the wait
  wire abs_start = delayed && !abs_running;
  wire abs_halt  = immediate || pkt_expire || flush_pulse
                   || abs_reload == '0;

  delay_timer u_abs_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .start_i   (abs_start),
    .halt_i    (abs_halt),
    .reload_i  (abs_reload),
    .running_o (abs_running),
    .expire_o  (abs_expire)
  );

  // Packet timer restarts on every delayed descriptor to coalesce completions
  wire pkt_halt = immediate || abs_expire || flush_pulse;

  delay_timer u_pkt_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .start_i   (delayed),
    .halt_i    (pkt_halt),
    .reload_i  (pkt_reload),
    .running_o (pkt_running),
    .expire_o  (pkt_expire)
  );

  wire complete_event = immediate || pkt_expire || abs_expire || flush_pulse;
  wire wb_flush_event = pkt_expire || abs_expire || flush_pulse;

  // ----------------------------------------------------------------
  // Prefetch control
  // ----------------------------------------------------------------
  tx_thresh_pkg::req_state_t fetch_state;
  logic [tx_thresh_pkg::CNT_W-1:0] onchip;

  wire [tx_thresh_pkg::CNT_W-1:0] buf_free  = tx_thresh_pkg::BUF_DESC - onchip;
  wire                            host_few  = host_avail_i < 16'(buf_free);
  wire [tx_thresh_pkg::CNT_W-1:0] fetch_num = host_few ? host_avail_i[tx_thresh_pkg::CNT_W-1:0]
                                                       : buf_free;
  wire consider    = 16'(onchip) < prefetch_desc;
  wire host_ready  = host_avail_i >= host_desc && host_avail_i != '0;
  wire fetch_start = fetch_state == tx_thresh_pkg::REQ_IDLE && consider && host_ready
                     && fetch_num != '0;
  wire fetch_done  = fetch_state == tx_thresh_pkg::REQ_BUSY && fetch_ack_i;
  wire onchip_dec  = desc_done && onchip != '0;

  wire [tx_thresh_pkg::CNT_W-1:0] fetch_add  = fetch_done ? fetch_count_o : '0;
  wire [tx_thresh_pkg::CNT_W-1:0] next_onchip = onchip + fetch_add
                                                - tx_thresh_pkg::CNT_W'(onchip_dec);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_state   <= tx_thresh_pkg::REQ_IDLE;
      fetch_count_o <= '0;
      fetch_bytes_o <= '0;
      onchip        <= '0;
    end else begin
      onchip <= next_onchip;
      if (fetch_start) begin
        fetch_state   <= tx_thresh_pkg::REQ_BUSY;
        fetch_count_o <= fetch_num;
        fetch_bytes_o <= to_bytes(fetch_num);
      end else if (fetch_done) begin
        fetch_state <= tx_thresh_pkg::REQ_IDLE;
      end
    end
  end

  assign fetch_req_o = fetch_state == tx_thresh_pkg::REQ_BUSY;

  // ----------------------------------------------------------------
  // Write-back control
  // ----------------------------------------------------------------
  tx_thresh_pkg::req_state_t wb_state;
  logic [tx_thresh_pkg::CNT_W-1:0] wb_pending;
  logic                            armed;
  logic                            flush_hold;

  // Bursting takes every descriptor after a report-status one until the pending write-back count drains to zero
  wire count_req  = desc_event_i.report_status;
  wire count_all  = qctl.granularity;
  wire count_arm  = burst_mode && (armed || desc_event_i.report_status);
  wire wb_inc     = desc_done && (count_req || count_all || count_arm);

  wire wb_reached = 16'(wb_pending) >= writeback_desc;
  wire wb_start   = wb_state == tx_thresh_pkg::REQ_IDLE && wb_pending != '0
                    && (wb_reached || flush_hold);
  wire wb_done    = wb_state == tx_thresh_pkg::REQ_BUSY && writeback_ack_i;

  wire [tx_thresh_pkg::CNT_W-1:0] wb_sub = wb_done ? writeback_count_o : '0;
  wire [tx_thresh_pkg::CNT_W-1:0] next_pending = wb_pending + tx_thresh_pkg::CNT_W'(wb_inc)
                                                 - wb_sub;
  wire next_armed = (desc_done && desc_event_i.report_status)
                    || (armed && next_pending != '0);

  // A flush that lands while a burst is in flight is kept for the next burst
  wire next_flush = wb_flush_event || (flush_hold && !wb_start);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state          <= tx_thresh_pkg::REQ_IDLE;
      wb_pending        <= '0;
      armed             <= 1'b0;
      flush_hold        <= 1'b0;
      writeback_count_o <= '0;
      writeback_bytes_o <= '0;
    end else begin
      wb_pending <= next_pending;
      armed      <= next_armed;
      flush_hold <= next_flush;
      if (wb_start) begin
        wb_state          <= tx_thresh_pkg::REQ_BUSY;
        writeback_count_o <= wb_pending;
        writeback_bytes_o <= to_bytes(wb_pending);
      end else if (wb_done) begin
        wb_state <= tx_thresh_pkg::REQ_IDLE;
      end
    end
  end

  assign writeback_req_o = wb_state == tx_thresh_pkg::REQ_BUSY;

  // ----------------------------------------------------------------
  // Descriptor-low detection
  // ----------------------------------------------------------------
  logic [15:0] prev_avail;

  wire [15:0] avail     = host_avail_i + 16'(onchip);
  wire [15:0] low_level = 16'(qctl.low_level) << tx_thresh_pkg::LOW_SHIFT;
  wire        low_hit   = qctl.low_level != '0
                          && prev_avail == low_level + 16'h0001
                          && avail == low_level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_avail          <= '0;
      desc_low_cause_o    <= 1'b0;
      tx_complete_cause_o <= 1'b0;
    end else begin
      prev_avail          <= avail;
      desc_low_cause_o    <= low_hit;
      tx_complete_cause_o <= complete_event;
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------
  wire [31:0] status_word = {12'h000, writeback_req_o, fetch_req_o, pkt_running, abs_running,
                             wb_pending, onchip};
  wire [31:0] rd_data = hit_qctl   ? qctl      :
                        hit_abs    ? abs_delay :
                        hit_pkt    ? pkt_delay :
                        hit_status ? status_word : 32'h0000_0000;

  // Every access is answered one cycle later; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule

// ==== verification/desc_mover_model.sv ====
// Descriptor mover stand-in that answers fetch and write-back requests
`timescale 1ns/100ps
module desc_mover_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  input  wire logic fetch_req_i,
  input  wire logic wback_req_i,
  output logic      fetch_ack_o = 1'b0,
  output logic      wback_ack_o = 1'b0
);
  // One pulse per request; a stall cycle stands in for slow host memory
  always @(posedge clk_i) begin
    fetch_ack_o <= !rst_i && fetch_req_i && !fetch_ack_o && !stall_i;
    wback_ack_o <= !rst_i && wback_req_i && !wback_ack_o && !stall_i;
  end
endmodule

// ==== verification/tx_descriptor_threshold_ctrl_monitor.sv ====
// Port-level assertions for the transmit descriptor threshold block
`timescale 1ns/100ps
module tx_descriptor_threshold_ctrl_monitor (
  input wire logic                              clk_i,
  input wire logic                              rst_i,
  input wire logic                              wb_cyc_i,
  input wire logic                              wb_stb_i,
  input wire logic                              wb_we_i,
  input wire logic [tx_thresh_pkg::ADR_W-1:0]   wb_adr_i,
  input wire logic [3:0]                        wb_sel_i,
  input wire logic [31:0]                       wb_dat_i,
  input wire logic                              wb_ack_o,
  input wire tx_thresh_pkg::desc_event_t        desc_event_i,
  input wire logic [15:0]                       host_avail_i,
  input wire logic                              fetch_req_o,
  input wire logic [tx_thresh_pkg::CNT_W-1:0]   fetch_count_o,
  input wire logic [tx_thresh_pkg::BYTES_W-1:0] fetch_bytes_o,
  input wire logic                              fetch_ack_i,
  input wire logic                              writeback_req_o,
  input wire logic [tx_thresh_pkg::CNT_W-1:0]   writeback_count_o,
  input wire logic [tx_thresh_pkg::BYTES_W-1:0] writeback_bytes_o,
  input wire logic                              tx_complete_cause_o,
  input wire logic                              desc_low_cause_o
);
  logic [6:0] low_lvl;
  logic [5:0] wthr;
  // Shadow of the fields the checks need, taken at the edge a write is accepted
  wire wr_ctl = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
              && wb_adr_i == tx_thresh_pkg::ADDR_QUEUE_CTL;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_lvl <= '0;
      wthr    <= '0;
    end else if (wr_ctl) begin
      if (wb_sel_i[3]) low_lvl <= wb_dat_i[31:25];
      if (wb_sel_i[2]) wthr <= wb_dat_i[21:16];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence immed_s;
    desc_event_i.done && desc_event_i.report_status && !desc_event_i.irq_delay_enable;
  endsequence
  sequence fetch_wait_s;
    fetch_req_o && !fetch_ack_i;
  endsequence
  fetch_bytes_a: assert property (
    fetch_req_o |-> fetch_bytes_o == {fetch_count_o, 4'h0})
    else $error("fetch bytes differ from count times 16");
  wb_bytes_a: assert property (
    writeback_req_o |-> writeback_bytes_o == {writeback_count_o, 4'h0})
    else $error("write-back bytes differ from count times 16");
  fetch_hold_a: assert property (fetch_wait_s |=> fetch_req_o && $stable(fetch_count_o))
    else $error("fetch request dropped or changed before ack");
  fetch_host_a: assert property (
    $rose(fetch_req_o) |-> 16'(fetch_count_o) <= $past(host_avail_i))
    else $error("fetch asks more than host holds");
  fetch_nz_a: assert property (fetch_req_o |-> fetch_count_o != '0)
    else $error("empty fetch request");
  wb_nz_a: assert property (writeback_req_o |-> writeback_count_o != '0)
    else $error("empty write-back request");
  low_zero_a: assert property (
    low_lvl == '0 && $past(low_lvl) == '0 |-> !desc_low_cause_o)
    else $error("descriptor-low raised with level zero");
  immed_once_a: assert property (
    immed_s |=> tx_complete_cause_o ##1 !tx_complete_cause_o)
    else $error("immediate interrupt missing or repeated");
  wthr_zero_a: assert property (
    wthr == '0 && desc_event_i.done && desc_event_i.report_status && !writeback_req_o
    |-> ##[1:3] writeback_req_o)
    else $error("write-back not prompt");
endmodule
bind tx_descriptor_threshold_ctrl tx_descriptor_threshold_ctrl_monitor u_mon (.*);

// ==== verification/tx_descriptor_threshold_ctrl_tb.sv ====
// Self-checking bench for the transmit descriptor threshold block
`timescale 1ns/100ps
module tx_descriptor_threshold_ctrl_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0, host_avail_i = 16'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, d, sr = 32'hE2D3C4A7;
  logic [7:0]  fetch_count_o, writeback_count_o;
  logic [11:0] fetch_bytes_o, writeback_bytes_o;
  logic        wb_ack_o, fetch_req_o, writeback_req_o, tx_complete_cause_o, desc_low_cause_o;
  logic        fetch_ack_i, writeback_ack_i;
  tx_thresh_pkg::desc_event_t desc_event_i = '0;
  int          fails = 0, checks_done = 0, t;
  tx_descriptor_threshold_ctrl u_tx_descriptor_threshold_ctrl (.*);
  desc_mover_model u_desc_mover_model (.clk_i(clk_i), .rst_i(rst_i), .stall_i(sr[3]),
    .fetch_req_i(fetch_req_o), .wback_req_i(writeback_req_o), .fetch_ack_o(fetch_ack_i),
    .wback_ack_o(writeback_ack_i));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) sr <= lfsr(sr);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_ctl(input logic [31:0] v);
    return {v[31:24], 2'h0, v[21:16], 2'h0, v[13:8], 2'h0, v[5:0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ev(input logic rpt, input logic dly);
    desc_event_i <= '{1'b1, 1'b1, rpt, dly};
    @(posedge clk_i);
    desc_event_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic watch(input logic low, input int n);
    t = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (t < 0 && (low ? desc_low_cause_o : tx_complete_cause_o) === 1'b1) t = i;
    end
  endtask
  task automatic conclude;
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run needs well under 1500 cycles; this bound only catches a hang
  initial begin
    repeat (10000) @(posedge clk_i);
    fails++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 16'h3828, 32'h0, 4'hF);
    cmp(rd, 32'h0);
    wb(1'b0, 16'h382C, 32'h0, 4'hF);
    cmp(rd, 32'h0);
    wb(1'b1, 16'h3828, 32'hFFFFFFFF, 4'h1);
    wb(1'b0, 16'h3828, 32'h0, 4'hF);
    cmp(rd, exp_ctl(32'hFF));
    wb(1'b1, 16'h382C, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 16'h382C, 32'h0, 4'hF);
    cmp(rd, 32'h0000FFFF);
    wb(1'b1, 16'h3900, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 16'h3900, 32'h0, 4'hF);
    cmp(rd, 32'h0);
    repeat (4) begin
      d = (sr & 32'hFE1F1F1F) | 32'h01000000;
      wb(1'b1, 16'h3828, d, 4'hF);
      wb(1'b0, 16'h3828, 32'h0, 4'hF);
      cmp(rd, exp_ctl(d));
    end
    wb(1'b1, 16'h3828, 32'h01001404, 4'hF);
    host_avail_i <= 16'hA;
    repeat (20) @(posedge clk_i);
    cmp(fetch_req_o, 1'b0);
    wb(1'b1, 16'h3828, 32'h01000204, 4'hF);
    do @(posedge clk_i); while (fetch_req_o !== 1'b1);
    cmp(fetch_count_o, 8'hA);
    cmp(fetch_bytes_o, 12'hA0);
    do @(posedge clk_i); while (fetch_req_o !== 1'b0);
    host_avail_i <= 16'h0;
    wb(1'b0, 16'h3830, 32'h0, 4'hF);
    cmp(rd & 32'hFF, 32'hA);
    wb(1'b1, 16'h3820, 32'h0FFF, 4'hF);
    wb(1'b1, 16'h382C, 32'h0FFF, 4'hF);
    wb(1'b1, 16'h3828, 32'h01030000, 4'hF);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    cmp(writeback_req_o, 1'b0);
    ev(1'b0, 1'b0);
    do @(posedge clk_i); while (writeback_req_o !== 1'b1);
    cmp(writeback_count_o, 8'h3);
    cmp(writeback_bytes_o, 12'h30);
    do @(posedge clk_i); while (writeback_req_o !== 1'b0);
    wb(1'b1, 16'h3828, 32'h01000000, 4'hF);
    ev(1'b0, 1'b0);
    do @(posedge clk_i); while (writeback_req_o !== 1'b1);
    cmp(writeback_count_o, 8'h1);
    do @(posedge clk_i); while (writeback_req_o !== 1'b0);
    for (int l = 1; l >= 0; l--) begin
      wb(1'b1, 16'h3828, {7'(l), 25'h1000000}, 4'hF);
      wb(1'b0, 16'h3830, 32'h0, 4'hF);
      host_avail_i <= 16'h9 - 16'(rd[7:0]);
      repeat (3) @(posedge clk_i);
      host_avail_i <= 16'h8 - 16'(rd[7:0]);
      watch(1'b1, 6);
      cmp(t >= 0, l == 1);
    end
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, 16'h382C, (k == 2) ? 32'h0 : 32'h2, 4'hF);
      ev(k != 1, 1'b1);
      watch(1'b0, 300);
      cmp((t >= 35 && t <= 130) ? 1 : (t < 0) ? 0 : 2, k == 0);
    end
    conclude();
  end
endmodule
